// file: src/bcd_core.sv
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "bcd_regs.svh"
module bcd_core #(
	parameter int FRAME_WORDS = 64,
	parameter int OH_WORDS = 3,
	parameter int ALN_DEPTH = 8
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// AHB-Lite register slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic [31:0] o_hrdata,
	output logic o_hresp,
	// User transmit side
	input wire logic [`BCD_NCH-1:0][31:0] i_tx_word,
	output logic [`BCD_NCH-1:0] o_tx_take,
	input wire logic [`BCD_CELL_BITS-1:0] i_cell_tx_data,
	input wire logic [`BCD_NGRP-1:0] i_cell_tx_valid,
	output logic [`BCD_NGRP-1:0] o_cell_tx_ready,
	// Serializer side
	output logic [`BCD_NCH-1:0][7:0] o_ser_tx_byte,
	input wire logic [`BCD_NCH-1:0][7:0] i_ser_rx_byte,
	// User receive side
	output logic [`BCD_NCH-1:0][31:0] o_rx_word,
	output logic [`BCD_NCH-1:0] o_rx_valid,
	output logic [`BCD_NCH-1:0] o_rx_spe,
	output logic [`BCD_NCH-1:0] o_rx_fp,
	output logic [`BCD_CELL_BITS-1:0] o_cell_rx_data,
	output logic [`BCD_NGRP-1:0] o_cell_rx_valid
);
	localparam int NCH = `BCD_NCH;
	localparam int LB = `BCD_LANE_BITS;
	localparam int FW = $clog2(FRAME_WORDS);
	localparam int AW = $clog2(ALN_DEPTH);
	localparam logic [FW-1:0] FLAST = FW'(FRAME_WORDS - 1);
	localparam logic [FW-1:0] OH_END = FW'(OH_WORDS);
	localparam logic [AW:0] FULL = (AW+1)'(ALN_DEPTH);
	// Reported only: a 50 MHz core gives a word rate below the legal floor
	localparam logic RATE_OK = ((`BCD_CLK_KHZ / `BCD_SER_PER_USR) >= `BCD_USR_MIN_KHZ) &&
		((`BCD_CLK_KHZ / `BCD_SER_PER_USR) <= `BCD_USR_MAX_KHZ);

	typedef struct packed {
		logic [1:0] ph;
		logic eight;
		logic [NCH-1:0][7:0] ctl;
		logic [NCH-1:0] lock;
		logic [NCH-1:0] ovf;
		logic [NCH-1:0] armed;
		logic [FW-1:0] tpos;
		logic [NCH-1:0][6:0] tlfsr;
		logic [NCH-1:0][31:0] tsh;
		logic [NCH-1:0][LB-1:0] cbuf;
		logic [NCH-1:0] cful;
		logic [NCH-1:0][23:0] rsh;
		logic [NCH-1:0][FW-1:0] rpos;
		logic [NCH-1:0][6:0] rlfsr;
		logic [NCH-1:0][ALN_DEPTH-1:0][33:0] mem;
		logic [NCH-1:0][AW-1:0] wp;
		logic [NCH-1:0][AW-1:0] rp;
		logic [NCH-1:0][AW:0] cnt;
		logic [NCH-1:0][31:0] rxw;
		logic [NCH-1:0] rxv;
		logic [NCH-1:0] rxspe;
		logic [NCH-1:0] rxfp;
		logic [`BCD_NGRP-1:0] cv;
		bcd_pkg::bcd_ahb_t ap;
		logic [31:0] rdata;
	} bcd_st_t;

	bcd_st_t r;
	bcd_st_t n;
	logic [NCH-1:0] lane_en;
	logic [NCH-1:0] lane_cell;
	logic [`BCD_NGRP-1:0] cready;
	logic wev;

	// 32 scrambler bits per word, first bit in the MSB
	function automatic logic [38:0] bcd_scr(input logic [6:0] seed);
		logic [6:0] s;
		logic [31:0] k;
		s = seed;
		k = '0;
		for (int i = 31; i >= 0; i--) begin
			k[i] = s[6];
			s = {s[5:0], s[6] ^ s[5]};
		end
		return {s, k};
	endfunction : bcd_scr

	// {hit, status, index} of a per-channel register
	function automatic logic [4:0] bcd_dec(input logic [11:0] a);
		logic hit;
		hit = (a[11:6] == `BCD_CH_PAGE) && (a[1:0] == '0);
		return {hit, a[`BCD_CH_STAT_BIT], a[`BCD_CH_IDX_F]};
	endfunction : bcd_dec

	// Serializer side moves a byte per clock, user side a word every fourth
	assign wev = (r.ph == `BCD_PH_LAST);

	genvar gl;
	generate
		for (gl = 0; gl < NCH; gl++) begin : g_lane
			assign lane_en[gl] = r.ctl[gl][`BCD_EN_BIT];
			assign lane_cell[gl] = lane_en[gl] &&
				(r.ctl[gl][`BCD_MODE_F] == bcd_pkg::BCD_CELL);
			assign o_ser_tx_byte[gl] = r.tsh[gl][31:24];
			assign o_cell_rx_data[gl*LB +: LB] = r.rxw[gl][LB-1:0];
			assign o_tx_take[gl] = lane_en[gl] && wev &&
				((r.ctl[gl][`BCD_MODE_F] == bcd_pkg::BCD_BYPASS) ||
				((r.ctl[gl][`BCD_MODE_F] == bcd_pkg::BCD_SONET) && (r.tpos >= OH_END)));
		end
		for (gl = 0; gl < `BCD_NGRP; gl++) begin : g_grp
			// Eight-link mode folds every lane into group zero
			assign cready[gl] = r.eight ?
				((gl == 0) && (&lane_cell) && !(|r.cful)) :
				((&lane_cell[2*gl+1:2*gl]) && !(|r.cful[2*gl+1:2*gl]));
		end
	endgenerate

	assign o_cell_tx_ready = cready;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = r.rdata;
	assign o_rx_word = r.rxw;
	assign o_rx_valid = r.rxv;
	assign o_rx_spe = r.rxspe;
	assign o_rx_fp = r.rxfp;
	assign o_cell_rx_valid = r.cv;

	always_comb begin
		logic [38:0] sc;
		logic [31:0] w;
		logic [31:0] d;
		logic [NCH-1:0] rdy;
		logic [NCH-1:0] rd;
		logic [4:0] dc;
		logic wr;
		logic oh;
		logic pat;
		logic spe;
		logic [1:0] m;
		bcd_pkg::bcd_aln_t e;
		n = r;
		sc = '0;
		w = '0;
		d = '0;
		rd = '0;
		wr = 1'b0;
		pat = 1'b0;
		spe = 1'b0;
		m = '0;
		e = '0;
		n.ph = r.ph + 2'h1;
		n.rxv = '0;
		n.cv = '0;
		oh = (r.tpos < OH_END);
		if (wev) begin
			n.tpos = (r.tpos == FLAST) ? '0 : r.tpos + 1'b1;
		end
		// Register writes land at the end of the data phase
		dc = bcd_dec(r.ap.addr);
		if (r.ap.act && r.ap.wr) begin
			if (r.ap.addr == `BCD_GCTRL) begin
				n.eight = i_hwdata[`BCD_EIGHT_BIT];
			end else if (dc[4] && !dc[3]) begin
				n.ctl[dc[2:0]] = i_hwdata[7:0];
			end else if (dc[4]) begin
				n.ovf[dc[2:0]] = 1'b0;
			end
		end
		for (int l = 0; l < NCH; l++) begin
			rdy[l] = (r.cnt[l] != '0);
		end
		for (int l = 0; l < NCH; l++) begin
			rd[l] = lane_en[l] && (r.ctl[l][`BCD_MODE_F] != bcd_pkg::BCD_BYPASS) &&
				(r.eight ? (&rdy) : (rdy[l] && rdy[l ^ 1]));
		end
		for (int l = 0; l < NCH; l++) begin
			m = r.ctl[l][`BCD_MODE_F];
			n.rsh[l] = {r.rsh[l][15:0], i_ser_rx_byte[l]};
			if (!lane_en[l]) begin
				// A disabled lane is the safe moment to retune it
				n.tsh[l] = '0;
				n.cful[l] = 1'b0;
				n.lock[l] = 1'b0;
				n.armed[l] = 1'b0;
				n.cnt[l] = '0;
				n.wp[l] = '0;
				n.rp[l] = '0;
			end else begin
				// Transmit
				if (!wev) begin
					n.tsh[l] = {r.tsh[l][23:0], 8'h00};
				end else if (m == bcd_pkg::BCD_BYPASS) begin
					n.tsh[l] = i_tx_word[l];
				end else begin
					if (m == bcd_pkg::BCD_CELL) begin
						w = r.cful[l] ? {`BCD_CELL_TAG, r.cbuf[l]} : '0;
					end else begin
						w = i_tx_word[l];
					end
					if (r.tpos == '0) begin
						w = `BCD_FRAME_PAT;
						n.tlfsr[l] = `BCD_LFSR_SEED;
					end else begin
						if (oh) begin
							w = '0;
						end else if (m == bcd_pkg::BCD_CELL) begin
							n.cful[l] = 1'b0;
						end
						sc = bcd_scr(r.tlfsr[l]);
						w = w ^ sc[31:0];
						n.tlfsr[l] = sc[38:32];
					end
					n.tsh[l] = w;
				end
				// Receive, word boundary follows the shared phase
				if (wev) begin
					w = {r.rsh[l], i_ser_rx_byte[l]};
					if (m == bcd_pkg::BCD_BYPASS) begin
						n.rxw[l] = w;
						n.rxv[l] = 1'b1;
						n.rxspe[l] = 1'b0;
						n.rxfp[l] = 1'b0;
					end else begin
						pat = (w == `BCD_FRAME_PAT);
						spe = !pat && (r.rpos[l] >= OH_END);
						if (pat) begin
							d = w;
							n.rpos[l] = FW'(1);
							n.rlfsr[l] = `BCD_LFSR_SEED;
							n.lock[l] = 1'b1;
							n.armed[l] = 1'b1;
						end else begin
							sc = bcd_scr(r.rlfsr[l]);
							d = w ^ sc[31:0];
							n.rlfsr[l] = sc[38:32];
							n.rpos[l] = (r.rpos[l] == FLAST) ? '0 : r.rpos[l] + 1'b1;
							if (r.rpos[l] == '0) begin
								n.lock[l] = 1'b0;
							end
						end
						if ((m == bcd_pkg::BCD_SONET) && r.ctl[l][`BCD_ALNBYP_BIT]) begin
							n.rxw[l] = d;
							n.rxv[l] = n.lock[l];
							n.rxspe[l] = spe;
							n.rxfp[l] = pat;
						end else if (n.armed[l] && n.lock[l]) begin
							wr = (m == bcd_pkg::BCD_SONET) ||
								((m == bcd_pkg::BCD_CELL) && spe &&
								(d[31:LB] == `BCD_CELL_TAG));
						end
					end
				end
				if (wr) begin
					if ((r.cnt[l] == FULL) && !rd[l]) begin
						wr = 1'b0;
						n.ovf[l] = 1'b1;
					end else begin
						e.fp = pat;
						e.spe = spe;
						e.w = d;
						n.mem[l][r.wp[l]] = e;
						n.wp[l] = r.wp[l] + 1'b1;
					end
				end
				if (rd[l]) begin
					e = r.mem[l][r.rp[l]];
					n.rp[l] = r.rp[l] + 1'b1;
					n.rxw[l] = e.w;
					if (m == bcd_pkg::BCD_CELL) begin
						n.cv[r.eight ? 0 : l / 2] = 1'b1;
					end else begin
						n.rxv[l] = 1'b1;
						n.rxspe[l] = e.spe;
						n.rxfp[l] = e.fp;
					end
				end
				n.cnt[l] = r.cnt[l] + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd[l]};
				wr = 1'b0;
				// Stripe: lane l always owns slice l of the cell word
				if (cready[r.eight ? 0 : l / 2] && i_cell_tx_valid[r.eight ? 0 : l / 2]) begin
					n.cbuf[l] = i_cell_tx_data[l*LB +: LB];
					n.cful[l] = 1'b1;
				end
			end
		end
		// Address phase; read data is built from the already updated state
		n.ap.act = i_hsel && i_htrans[1] && i_hready;
		n.ap.wr = i_hwrite;
		n.ap.addr = i_haddr[11:0];
		n.rdata = '0;
		dc = bcd_dec(i_haddr[11:0]);
		if (n.ap.act && !i_hwrite) begin
			if (i_haddr[11:0] == `BCD_GCTRL) begin
				n.rdata[`BCD_EIGHT_BIT] = n.eight;
			end else if (i_haddr[11:0] == `BCD_GSTAT) begin
				n.rdata[`BCD_GST_RATE] = RATE_OK;
			end else if (dc[4] && !dc[3]) begin
				n.rdata[7:0] = n.ctl[dc[2:0]];
			end else if (dc[4]) begin
				n.rdata[`BCD_ST_LOCK] = n.lock[dc[2:0]];
				n.rdata[`BCD_ST_NEMPTY] = (n.cnt[dc[2:0]] != '0);
				n.rdata[`BCD_ST_OVF] = n.ovf[dc[2:0]];
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	chk_bypass_tx: assert property (
		(wev && lane_en[0] && r.ctl[0][`BCD_MODE_F] == bcd_pkg::BCD_BYPASS)
		##1 lane_en[0]
		|-> o_ser_tx_byte[0] == $past(i_tx_word[0][31:24]) ##1
		o_ser_tx_byte[0] == $past(i_tx_word[0][23:16], 2))
		else $error("bypass word not sent MSB first");

	chk_frame_word: assert property (
		(wev && lane_en[0] && r.ctl[0][`BCD_MODE_F] == bcd_pkg::BCD_SONET && r.tpos == '0)
		##1 lane_en[0] ##1 lane_en[0]
		|=> o_ser_tx_byte[0] == 8'h28 && $past(o_ser_tx_byte[0], 2) == 8'hF6)
		else $error("frame word missing at frame start");

	chk_scr_seed: assert property (
		(wev && lane_en[0] && r.ctl[0][`BCD_MODE_F] != bcd_pkg::BCD_BYPASS && r.tpos == FW'(1) &&
		$past(lane_en[0], 4) && $past(r.ctl[0][`BCD_MODE_F], 4) != bcd_pkg::BCD_BYPASS)
		|-> r.tlfsr[0] == `BCD_LFSR_SEED)
		else $error("scrambler not seeded after frame word");

	chk_rx_bypass: assert property (
		(wev && lane_en[0] && r.ctl[0][`BCD_MODE_F] == bcd_pkg::BCD_BYPASS)
		|=> o_rx_valid[0] && o_rx_word[0] == $past({r.rsh[0], i_ser_rx_byte[0]}))
		else $error("bypass receive word wrong");

	chk_fp_no_spe: assert property (
		o_rx_valid[0] && o_rx_fp[0] |-> !o_rx_spe[0])
		else $error("payload flagged on frame word");

	chk_group_fp: assert property (
		(!r.eight && r.rxv[0] && r.rxv[1] && !r.ctl[0][`BCD_ALNBYP_BIT] &&
		!r.ctl[1][`BCD_ALNBYP_BIT]) |-> r.rxfp[0] == r.rxfp[1])
		else $error("lanes of a pair not aligned");

	chk_cell_take: assert property (
		cready[0] && i_cell_tx_valid[0] |=> r.cful[0] && r.cful[1] &&
		r.cbuf[1] == $past(i_cell_tx_data[2*LB-1:LB]))
		else $error("cell slice not striped to lane");

	chk_eight_grp: assert property (
		r.eight && $past(r.eight) |-> r.cv[`BCD_NGRP-1:1] == '0 && cready[`BCD_NGRP-1:1] == '0)
		else $error("extra group active in eight-link mode");

	chk_gctrl_wr: assert property (
		r.ap.act && r.ap.wr && r.ap.addr == `BCD_GCTRL
		|=> r.eight == $past(i_hwdata[`BCD_EIGHT_BIT]))
		else $error("global control write lost");

endmodule : bcd_core

// file: src/bcd_pkg.sv
package bcd_pkg;
	typedef enum logic [1:0] {BCD_BYPASS, BCD_SONET, BCD_CELL, BCD_IDLE} bcd_mode_t;
	typedef struct packed {
		logic act;
		logic wr;
		logic [11:0] addr;
	} bcd_ahb_t;
	typedef struct packed {
		logic fp;
		logic spe;
		logic [31:0] w;
	} bcd_aln_t;
endpackage : bcd_pkg

// file: src/bcd_regs.svh
`ifndef BCD_REGS_SVH
`define BCD_REGS_SVH
`define BCD_NCH 8
`define BCD_NGRP 4
`define BCD_LANE_BITS 20
`define BCD_CELL_BITS 160
`define BCD_GCTRL 12'h000
`define BCD_GSTAT 12'h004
`define BCD_CH_PAGE 6'h01
`define BCD_CH_STAT_BIT 2
`define BCD_CH_IDX_F 5:3
`define BCD_MODE_F 1:0
`define BCD_ALNBYP_BIT 2
`define BCD_EN_BIT 3
`define BCD_EIGHT_BIT 0
`define BCD_ST_LOCK 0
`define BCD_ST_NEMPTY 1
`define BCD_ST_OVF 2
`define BCD_GST_RATE 0
`define BCD_FRAME_PAT 32'hF6F6_2828
`define BCD_CELL_TAG 12'hC35
`define BCD_LFSR_SEED 7'h7F
`define BCD_PH_LAST 2'h3
`define BCD_CLK_KHZ 50000
`define BCD_SER_PER_USR 4
`define BCD_USR_MIN_KHZ 18750
`define BCD_USR_MAX_KHZ 84380
`endif

// file: verification/bcd_far_end.sv
`timescale 1ns/1ps
module bcd_far_end (
	// Serializer side of the link
	input wire logic [7:0][7:0] i_ser_tx_byte,
	// Deserializer side of the link
	output logic [7:0][7:0] o_ser_rx_byte
);
	// Remote end echoes each lane on the same byte clock, so the word phase stays shared
	assign o_ser_rx_byte = i_ser_tx_byte;
endmodule : bcd_far_end

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
	logic i_core_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [7:0][31:0] tx_word = '0;
	logic [7:0] tx_take;
	logic [159:0] cell_tx = '0;
	logic [3:0] cell_valid = '0;
	logic [3:0] cell_ready;
	logic [7:0][7:0] ser_tx;
	logic [7:0][7:0] ser_rx;
	logic [7:0][31:0] rx_word;
	logic [7:0] rx_valid;
	logic [7:0] rx_spe;
	logic [7:0] rx_fp;
	logic [159:0] cell_rx;
	logic [3:0] cell_rx_valid;
	int fail_count = 0;
	int checked = 0;
	int n;
	always #10 i_core_clk = ~i_core_clk;
	bcd_core #(.FRAME_WORDS(16), .OH_WORDS(3), .ALN_DEPTH(4)) dut (
		.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_hsel(1'b1), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
		.i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
		.i_tx_word(tx_word), .o_tx_take(tx_take), .i_cell_tx_data(cell_tx),
		.i_cell_tx_valid(cell_valid), .o_cell_tx_ready(cell_ready), .o_ser_tx_byte(ser_tx),
		.i_ser_rx_byte(ser_rx), .o_rx_word(rx_word), .o_rx_valid(rx_valid), .o_rx_spe(rx_spe),
		.o_rx_fp(rx_fp), .o_cell_rx_data(cell_rx), .o_cell_rx_valid(cell_rx_valid));
	bcd_far_end far (.i_ser_tx_byte(ser_tx), .o_ser_rx_byte(ser_rx));
	task end_of_test;
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// Read data is taken at the edge that ends the data phase
	task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		do begin
			@(posedge i_core_clk);
		end while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(posedge i_core_clk);
			rd = hrdata;
		end while (hready !== 1'b1);
	endtask : bus
	task rchk(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		cmp(rd, exp);
	endtask : rchk
	// Ends at a falling edge where the chosen flag is high
	task wait_for(input int k, input int l);
		logic b;
		for (n = 0; n < 600; n++) begin
			@(negedge i_core_clk);
			case (k)
				0: b = tx_take[l];
				1: b = rx_fp[l];
				2: b = rx_valid[l] & rx_spe[l];
				3: b = cell_rx_valid[l];
				default: b = cell_ready[l];
			endcase
			if (b === 1'b1) break;
		end
		if (n == 600) cmp(32'h0000_0000, 32'h0000_0001);
	endtask : wait_for
	// Each lane carrying the cell must first lock on a frame word, or the cell arrives unframed and is dropped
	task cell_run;
		repeat (80) @(posedge i_core_clk);
		wait_for(4, 0);
		@(posedge i_core_clk);
		cell_valid[0] <= 1'b1;
		do begin
			@(posedge i_core_clk);
		end while (cell_ready[0] !== 1'b1);
		cell_valid[0] <= 1'b0;
		wait_for(3, 0);
	endtask : cell_run
	initial begin
		#1_000_000;
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		@(posedge i_core_clk);
		rchk(32'h0000_0000, 32'h0000_0000);
		cmp({31'h0, hresp}, 32'h0000_0000);
		rchk(32'h0000_0004, 32'h0000_0000);
		rchk(32'h0000_0100, 32'h0000_0000);
		bus(1'b1, 32'h0000_0040, 32'h0000_0F07);
		rchk(32'h0000_0040, 32'h0000_0007);
		tx_word[0] <= 32'hA5C3_0F1E;
		tx_word[1] <= 32'h3C69_96C3;
		bus(1'b1, 32'h0000_0040, 32'h0000_0008);
		wait_for(0, 0);
		@(negedge i_core_clk);
		cmp({24'h00_0000, ser_tx[0]}, 32'h0000_00A5);
		@(negedge i_core_clk);
		cmp({24'h00_0000, ser_tx[0]}, 32'h0000_00C3);
		cmp({24'h00_0000, ser_tx[1]}, 32'h0000_0000);
		repeat (12) @(negedge i_core_clk);
		cmp(rx_word[0], 32'hA5C3_0F1E);
		bus(1'b1, 32'h0000_0040, 32'h0000_0000);
		bus(1'b1, 32'h0000_0040, 32'h0000_000D);
		wait_for(1, 0);
		wait_for(2, 0);
		cmp(rx_word[0], 32'hA5C3_0F1E);
		rchk(32'h0000_0044, 32'h0000_0001);
		bus(1'b1, 32'h0000_0040, 32'h0000_0000);
		bus(1'b1, 32'h0000_0040, 32'h0000_0009);
		bus(1'b1, 32'h0000_0048, 32'h0000_0009);
		wait_for(1, 0);
		wait_for(2, 0);
		cmp(rx_word[0], 32'hA5C3_0F1E);
		cmp(rx_word[1], 32'h3C69_96C3);
		cmp({31'h0, rx_valid[1] & rx_spe[1]}, 32'h0000_0001);
		bus(1'b1, 32'h0000_0040, 32'h0000_0000);
		bus(1'b1, 32'h0000_0048, 32'h0000_0000);
		bus(1'b1, 32'h0000_0040, 32'h0000_000A);
		bus(1'b1, 32'h0000_0048, 32'h0000_000A);
		cell_tx[39:0] <= 40'h12_3456_789A;
		cell_run();
		cmp(cell_rx[31:0], 32'h3456_789A);
		cmp({24'h00_0000, cell_rx[39:32]}, 32'h0000_0012);
		@(negedge i_core_clk);
		cmp({31'h0, cell_rx_valid[0]}, 32'h0000_0000);
		bus(1'b1, 32'h0000_0040, 32'h0000_0000);
		bus(1'b1, 32'h0000_0048, 32'h0000_0000);
		bus(1'b1, 32'h0000_0000, 32'h0000_0001);
		for (int i = 0; i < 8; i++) bus(1'b1, 32'h0000_0040 + 8 * i, 32'h0000_000A);
		cell_tx <= 160'h0123_4567_89AB_CDEF_0123_4567_89AB_CDEF_0123_4567;
		cell_run();
		cmp(cell_rx[159:128], 32'h0123_4567);
		cmp(cell_rx[31:0], 32'h0123_4567);
		end_of_test();
	end
endmodule : tb
